// file: logic/ir_pulse_encoder.sv
`timescale 1ns/1ns
module ir_pulse_encoder
   import serial_pin_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       enable,
   input  wire logic       bitStart,
   input  wire logic       txBit,
   input  wire logic       baseTick,
   input  wire logic [2:0] widthSel,
   output logic            pulse
);
   logic [4:0] target;
   logic [4:0] count;
   logic       unitTick;

   // Pulse length per width code; zero marks a prohibited code
   always_comb begin
      case (widthSel)
         IR_W_3_16: target = IR_LEN_3_16;
         IR_W_DIV2: target = IR_LEN_DIV2;
         IR_W_DIV4: target = IR_LEN_DIV4;
         IR_W_DIV8: target = IR_LEN_DIV8;
         IR_W_DIV16: target = IR_LEN_DIV16;
         default: target = ZERO_BYTE[4:0];
      endcase
   end

   // Bit-rate code counts basic clock ticks (16x or 8x), the others system clocks
   assign unitTick = (widthSel == IR_W_3_16) ? baseTick : 1'b1;

   // High pulse at the start of each zero bit
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pulse <= 1'b0;
         count <= 5'h00;
      end else if (!enable) begin
         pulse <= 1'b0;
         count <= 5'h00;
      end else if (!pulse) begin
         if (bitStart && !txBit && target != 5'h00) begin
            pulse <= 1'b1;
            count <= 5'h00;
         end
      end else if (unitTick) begin
         if (count == target - 5'h01) begin
            pulse <= 1'b0;
         end else begin
            count <= count + 5'h01;
         end
      end
   end

   property p_div2_width;
      @(posedge sys_clk) disable iff (reset)
      $rose(pulse) && enable && widthSel == IR_W_DIV2 |-> pulse[*2] ##1 !pulse;
   endproperty
   a_div2_width: assert property (p_div2_width) else $error("div2 pulse not two cycles");

   property p_div16_width;
      @(posedge sys_clk) disable iff (reset)
      $rose(pulse) && enable && widthSel == IR_W_DIV16 |-> ##15 pulse ##1 !pulse;
   endproperty
   a_div16_width: assert property (p_div16_width) else $error("div16 pulse not sixteen cycles");
endmodule

// file: logic/serial_pin_pkg.sv
package serial_pin_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CHAN3_PORT_CONTROL = 8'h00;
   localparam logic [7:0] OFF_INFRARED_CONTROL   = 8'h04;
   localparam logic [7:0] OFF_EXTENDED_MODE      = 8'h08;
   localparam logic [7:0] OFF_CHAN1_MODE         = 8'h0C;
   localparam logic [7:0] OFF_PIN_STATUS         = 8'h10;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_TX_PIN_SELECT = 4;
   localparam int BIT_TX_INVERT     = 1;
   localparam int BIT_RX_INVERT     = 0;
   localparam int BIT_IR_ENABLE     = 7;
   localparam int BIT_IR_WIDTH_LO   = 4;
   localparam int BIT_BASIC_CLOCK   = 3;
   localparam int BIT_SYNC_MODE     = 0;

   // Fixed read values of reserved bits
   localparam logic [7:0] PORT_CTRL_ONES = 8'hEC;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;

   // ----------------------------------------
   // Infrared pulse width codes and lengths
   // ----------------------------------------
   typedef enum logic [2:0] {
      IR_W_3_16 = 3'h0,
      IR_W_DIV2 = 3'h1,
      IR_W_DIV4 = 3'h2,
      IR_W_DIV8 = 3'h3,
      IR_W_DIV16 = 3'h4
   } ir_width_t;
   localparam logic [4:0] IR_LEN_3_16 = 5'h03;
   localparam logic [4:0] IR_LEN_DIV2 = 5'h02;
   localparam logic [4:0] IR_LEN_DIV4 = 5'h04;
   localparam logic [4:0] IR_LEN_DIV8 = 5'h08;
   localparam logic [4:0] IR_LEN_DIV16 = 5'h10;

   // ----------------------------------------
   // Oversampling ratios
   // ----------------------------------------
   localparam logic [4:0] RATIO_16 = 5'h10;
   localparam logic [4:0] RATIO_8  = 5'h08;
endpackage

// file: logic/serial_port_pin_irda_control.sv
// What this block does
// - Port control bit 4 gives the shared pin to port I/O or channel-3 transmit.
// - Port control bit 1 inverts the channel-3 transmit pin level.
// - Port control bit 0 inverts the sampled channel-3 receive pin level.
// - Port control bits 7 to 5 and 3 to 2 read as one, writes ignored.
// - Inversion changes act at once on the pin path, even mid-transfer.
// - Infrared control bit 7 routes channel-1 pins to plain or infrared coding.
// - Width field bits 6 to 4 set infrared pulse: 3 basic clock ticks (3/16 bit at 16x, 3/8 at 8x), clock/2, /4, /8, /16.
// - Infrared control bits 3 to 0 read as zero, writes ignored.
// - Extended mode bit 3 picks 16x or 8x basic clock per bit.
// - Basic clock select acts only in asynchronous mode.
// - Extended mode bits 7 to 4 written zero; bits 2 to 0 read zero.
// - Receiver syncs on start edge, samples on 8th of 16 or 4th of 8 ticks.
`timescale 1ns/1ns
module serial_port_pin_irda_control
   import serial_pin_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Channel-3 transmitter side and shared port pin
   input  wire logic        chan3TxData,
   input  wire logic        portOutData,
   input  wire logic        portDriveEnable,
   output logic             portInData,
   input  wire logic        sharedPinIn,
   output logic             sharedPinOut,
   output logic             sharedPinOeN,
   input  wire logic        chan3RxPin,
   output logic             chan3RxData,
   // Channel-1 serial engine side
   input  wire logic        chan1TxData,
   input  wire logic        chan1BitStart,
   input  wire logic        oversampleTick,
   input  wire logic        chan1FrameDone,
   output logic             chan1TxPin,
   input  wire logic        chan1RxPin,
   output logic             chan1RxData,
   output logic             chan1SampleStrobe,
   output logic             chan1Oversample8
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic       txPinSelect;
   logic       txInvert;
   logic       rxInvert;
   logic       infraredEnable;
   logic [2:0] pulseWidthSelect;
   logic       basicClockSelect;
   logic       syncMode;

   logic       setupPhase;
   logic       writeStrobe;
   logic [7:0] next_readByte;
   logic       next_slvErr;

   // ----------------------------------------
   // Pin synchronisers and receive path
   // ----------------------------------------
   logic [1:0] chan3RxSync;
   logic [1:0] chan1RxSync;
   logic [1:0] portInSync;
   logic       chan1Level;
   logic       chan1Prev;
   logic       irPulse;
   logic       rxBusy;
   logic [4:0] tickCount;
   logic [4:0] ratio;

   assign setupPhase  = psel && !penable;
   assign writeStrobe = psel && penable && pready && pwrite;

   // ----------------------------------------
   // APB read mux and decode
   // ----------------------------------------
   always_comb begin
      next_readByte = ZERO_BYTE;
      next_slvErr   = 1'b0;
      case (paddr)
         OFF_CHAN3_PORT_CONTROL: begin
            next_readByte = PORT_CTRL_ONES;
            next_readByte[BIT_TX_PIN_SELECT] = txPinSelect;
            next_readByte[BIT_TX_INVERT]     = txInvert;
            next_readByte[BIT_RX_INVERT]     = rxInvert;
         end
         OFF_INFRARED_CONTROL: begin
            next_readByte[BIT_IR_ENABLE] = infraredEnable;
            next_readByte[BIT_IR_WIDTH_LO +: 3] = pulseWidthSelect;
         end
         OFF_EXTENDED_MODE: begin
            next_readByte[BIT_BASIC_CLOCK] = basicClockSelect;
         end
         OFF_CHAN1_MODE: begin
            next_readByte[BIT_SYNC_MODE] = syncMode;
         end
         OFF_PIN_STATUS: begin
            next_readByte[3:0] = {rxBusy, portInData, chan1RxData, chan3RxData};
         end
         default: begin
            next_slvErr = 1'b1;
         end
      endcase
   end

   // One wait-free access phase: answer prepared during setup
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setupPhase) begin
         pready  <= 1'b1;
         pslverr <= next_slvErr;
         prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_readByte};
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Register writes; reserved bits never stored
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         txPinSelect      <= 1'b0;
         txInvert         <= 1'b0;
         rxInvert         <= 1'b0;
         infraredEnable   <= 1'b0;
         pulseWidthSelect <= 3'h0;
         basicClockSelect <= 1'b0;
         syncMode         <= 1'b0;
      end else if (writeStrobe) begin
         case (paddr)
            OFF_CHAN3_PORT_CONTROL: begin
               txPinSelect <= pwdata[BIT_TX_PIN_SELECT];
               txInvert    <= pwdata[BIT_TX_INVERT];
               rxInvert    <= pwdata[BIT_RX_INVERT];
            end
            OFF_INFRARED_CONTROL: begin
               infraredEnable   <= pwdata[BIT_IR_ENABLE];
               pulseWidthSelect <= pwdata[BIT_IR_WIDTH_LO +: 3];
            end
            OFF_EXTENDED_MODE: begin
               basicClockSelect <= pwdata[BIT_BASIC_CLOCK];
            end
            OFF_CHAN1_MODE: begin
               syncMode <= pwdata[BIT_SYNC_MODE];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Two-stage synchronisers on pin inputs
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         chan3RxSync <= 2'h3;
         chan1RxSync <= 2'h3;
         portInSync  <= 2'h0;
      end else begin
         chan3RxSync <= {chan3RxSync[0], chan3RxPin};
         chan1RxSync <= {chan1RxSync[0], chan1RxPin};
         portInSync  <= {portInSync[0], sharedPinIn};
      end
   end

   // ----------------------------------------
   // Channel-3 and shared pin path
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sharedPinOut <= 1'b0;
         sharedPinOeN <= 1'b1;
         chan3RxData  <= 1'b1;
         portInData   <= 1'b0;
      end else begin
         if (txPinSelect) begin
            sharedPinOut <= chan3TxData ^ txInvert;
            sharedPinOeN <= 1'b0;
         end else begin
            sharedPinOut <= portOutData;
            sharedPinOeN <= !portDriveEnable;
         end
         chan3RxData <= chan3RxSync[1] ^ rxInvert;
         portInData  <= portInSync[1];
      end
   end

   // ----------------------------------------
   // Channel-1 transmit routing
   // ----------------------------------------
   ir_pulse_encoder u_encoder (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .enable   (infraredEnable),
      .bitStart (chan1BitStart),
      .txBit    (chan1TxData),
      .baseTick (oversampleTick),
      .widthSel (pulseWidthSelect),
      .pulse    (irPulse)
   );

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         chan1TxPin <= 1'b1;
      end else begin
         chan1TxPin <= infraredEnable ? irPulse : chan1TxData;
      end
   end

   // ----------------------------------------
   // Channel-1 receive level and basic clock
   // ----------------------------------------
   // Infrared receive pulse high means a zero bit
   assign chan1Level = infraredEnable ? !chan1RxSync[1] : chan1RxSync[1];
   assign ratio      = chan1Oversample8 ? RATIO_8 : RATIO_16;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         chan1Oversample8 <= 1'b0;
         chan1RxData      <= 1'b1;
         chan1Prev        <= 1'b1;
      end else begin
         chan1Oversample8 <= basicClockSelect && !syncMode;
         chan1RxData      <= chan1Level;
         chan1Prev        <= chan1Level;
      end
   end

   // ----------------------------------------
   // Start edge sync and mid-bit sample strobe
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rxBusy            <= 1'b0;
         tickCount         <= 5'h00;
         chan1SampleStrobe <= 1'b0;
      end else begin
         chan1SampleStrobe <= 1'b0;
         if (syncMode || chan1FrameDone) begin
            rxBusy <= 1'b0;
         end else if (!rxBusy) begin
            if (chan1Prev && !chan1Level) begin
               rxBusy    <= 1'b1;
               tickCount <= 5'h00;
            end
         end else if (oversampleTick) begin
            // Half ratio-th tick is the bit centre
            if (tickCount == (ratio >> 1) - 5'h01) begin
               chan1SampleStrobe <= 1'b1;
            end
            if (tickCount == ratio - 5'h01) begin
               tickCount <= 5'h00;
            end else begin
               tickCount <= tickCount + 5'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_pin_select;
      @(posedge sys_clk) disable iff (reset)
      txPinSelect |=> !sharedPinOeN;
   endproperty
   a_pin_select: assert property (p_pin_select) else $error("shared pin not driven as tx");

   property p_tx_invert;
      @(posedge sys_clk) disable iff (reset)
      txPinSelect |=> sharedPinOut == ($past(chan3TxData) ^ $past(txInvert));
   endproperty
   a_tx_invert: assert property (p_tx_invert) else $error("tx pin level wrong");

   property p_rx_invert_now;
      @(posedge sys_clk) disable iff (reset)
      $changed(rxInvert) |=> chan3RxData == ($past(chan3RxSync[1]) ^ $past(rxInvert));
   endproperty
   a_rx_invert_now: assert property (p_rx_invert_now) else $error("rx inversion late");

   property p_port_ctrl_ones;
      @(posedge sys_clk) disable iff (reset)
      psel && penable && pready && !pwrite && paddr == OFF_CHAN3_PORT_CONTROL
         |-> (prdata[7:0] & PORT_CTRL_ONES) == PORT_CTRL_ONES;
   endproperty
   a_port_ctrl_ones: assert property (p_port_ctrl_ones) else $error("reserved bits not one");

   property p_ir_low_zero;
      @(posedge sys_clk) disable iff (reset)
      psel && penable && pready && !pwrite && paddr == OFF_INFRARED_CONTROL |-> prdata[3:0] == 4'h0;
   endproperty
   a_ir_low_zero: assert property (p_ir_low_zero) else $error("infrared reserved bits set");

   property p_ext_zero;
      @(posedge sys_clk) disable iff (reset)
      psel && penable && pready && !pwrite && paddr == OFF_EXTENDED_MODE
         |-> prdata[7:4] == 4'h0 && prdata[2:0] == 3'h0;
   endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("extended reserved bits set");

   property p_ir_route;
      @(posedge sys_clk) disable iff (reset)
      !infraredEnable ##1 !infraredEnable |-> chan1TxPin == $past(chan1TxData);
   endproperty
   a_ir_route: assert property (p_ir_route) else $error("plain tx not routed");

   property p_basic_clock;
      @(posedge sys_clk) disable iff (reset)
      syncMode ##1 syncMode |-> !chan1Oversample8;
   endproperty
   a_basic_clock: assert property (p_basic_clock) else $error("8x active in sync mode");

   property p_first_sample;
      @(posedge sys_clk) disable iff (reset)
      $rose(rxBusy) && !chan1Oversample8 ##1 (!oversampleTick && rxBusy && !syncMode)[*8]
         |-> !chan1SampleStrobe;
   endproperty
   a_first_sample: assert property (p_first_sample) else $error("strobe without tick");

   c_ir_tx: cover property (@(posedge sys_clk) disable iff (reset) infraredEnable && $rose(chan1TxPin));
   c_sample: cover property (@(posedge sys_clk) disable iff (reset) chan1SampleStrobe && chan1Oversample8);
   c_chan3_inv: cover property (@(posedge sys_clk) disable iff (reset) txPinSelect && txInvert && !sharedPinOut);
   c_bad_addr: cover property (@(posedge sys_clk) disable iff (reset) pready && pslverr);
endmodule

// file: sim/serial_line_model.sv
`timescale 1ns/1ns
module serial_line_model (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       sharedPinOut,
   input  wire logic       sharedPinOeN,
   input  wire logic       chan1TxPin,
   input  wire logic       chan3Level,
   input  wire logic       chan1Level,
   output logic            sharedPinIn,
   output logic            chan3RxPin,
   output logic            chan1RxPin,
   output logic [7:0]      pulseLen
);
   logic [7:0] highCnt;

   // ----------------------------------------
   // Line levels
   // ----------------------------------------
   // Shared pin has a pull-up when nobody drives it
   assign sharedPinIn = sharedPinOeN ? 1'b1 : sharedPinOut;
   assign chan3RxPin  = chan3Level;
   assign chan1RxPin  = chan1Level;

   // ----------------------------------------
   // Infrared receiver
   // ----------------------------------------
   // Measures each high pulse in clock cycles
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         highCnt  <= 8'h00;
         pulseLen <= 8'h00;
      end else if (chan1TxPin) begin
         highCnt <= highCnt + 8'h01;
      end else begin
         if (highCnt != 8'h00) begin
            pulseLen <= highCnt;
         end
         highCnt <= 8'h00;
      end
   end
endmodule

// file: sim/test_serial_port_pin_irda_control.sv
`timescale 1ns/1ns
module test_serial_port_pin_irda_control
   import serial_pin_pkg::*;
;
   logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, pulseLen;
   logic [31:0] pwdata, prdata;
   logic        chan3TxData, portOutData, portDriveEnable, portInData, sharedPinIn, sharedPinOut;
   logic        sharedPinOeN, chan3RxPin, chan3RxData, chan1TxData, chan1BitStart, oversampleTick;
   logic        chan1FrameDone, chan1TxPin, chan1RxPin, chan1RxData, chan1SampleStrobe;
   logic        chan1Oversample8, chan3Level, chan1Level;
   logic [1:0]  tickMode;
   int          cyc, errorCnt, checkCount;

   serial_port_pin_irda_control DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan3TxData(chan3TxData), .portOutData(portOutData),
      .portDriveEnable(portDriveEnable), .portInData(portInData), .sharedPinIn(sharedPinIn),
      .sharedPinOut(sharedPinOut), .sharedPinOeN(sharedPinOeN), .chan3RxPin(chan3RxPin),
      .chan3RxData(chan3RxData), .chan1TxData(chan1TxData), .chan1BitStart(chan1BitStart),
      .oversampleTick(oversampleTick), .chan1FrameDone(chan1FrameDone), .chan1TxPin(chan1TxPin),
      .chan1RxPin(chan1RxPin), .chan1RxData(chan1RxData), .chan1SampleStrobe(chan1SampleStrobe),
      .chan1Oversample8(chan1Oversample8));

   serial_line_model partner (.sys_clk(sys_clk), .reset(reset), .sharedPinOut(sharedPinOut),
      .sharedPinOeN(sharedPinOeN), .chan1TxPin(chan1TxPin), .chan3Level(chan3Level),
      .chan1Level(chan1Level), .sharedPinIn(sharedPinIn), .chan3RxPin(chan3RxPin),
      .chan1RxPin(chan1RxPin), .pulseLen(pulseLen));

   // ----------------------------------------
   // Clock, tick source and timeout
   // ----------------------------------------
   always #20 sys_clk = ~sys_clk;

   // Tick every cycle, every fourth cycle, or never
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      oversampleTick <= (tickMode == 2'h2) || (tickMode == 2'h1 && cyc[1:0] == 2'h0);
      if (cyc == 20000) begin
         errorCnt++;
         summarize();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h000000, d}, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(r, {24'h000000, x});
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset values, reserved bits and an unmapped address
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd(OFF_CHAN3_PORT_CONTROL, 8'hEC);
      rd(OFF_INFRARED_CONTROL, 8'h00);
      rd(OFF_EXTENDED_MODE, 8'h00);
      wr(OFF_CHAN3_PORT_CONTROL, 8'h00);
      rd(OFF_CHAN3_PORT_CONTROL, 8'hEC);
      wr(OFF_INFRARED_CONTROL, 8'hBF);
      rd(OFF_INFRARED_CONTROL, 8'hB0);
      wr(OFF_EXTENDED_MODE, 8'h0F);
      rd(OFF_EXTENDED_MODE, 8'h08);
      wr(OFF_INFRARED_CONTROL, 8'h00);
      wr(OFF_EXTENDED_MODE, 8'h00);
      apb(1'b0, 8'h20, 32'h00000000, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
   endtask

   // Shared pin role, transmit and receive inversion
   task automatic t_chan3();
      portDriveEnable <= 1'b1;
      step(5);
      chk({30'h0, sharedPinOeN, portInData}, 32'h0);
      portDriveEnable <= 1'b0;
      step(5);
      chk({30'h0, sharedPinOeN, portInData}, 32'h3);
      wr(OFF_CHAN3_PORT_CONTROL, 8'h10);
      chan3TxData <= 1'b0;
      step(3);
      chk({30'h0, sharedPinOeN, sharedPinOut}, 32'h0);
      chan3TxData <= 1'b1;
      step(3);
      wr(OFF_CHAN3_PORT_CONTROL, 8'h12);
      step(2);
      chk({30'h0, sharedPinOeN, sharedPinOut}, 32'h0);
      chan3TxData <= 1'b0;
      step(3);
      chk({31'h0, sharedPinOut}, 32'h1);
      chan3Level <= 1'b0;
      step(5);
      chk({31'h0, chan3RxData}, 32'h0);
      wr(OFF_CHAN3_PORT_CONTROL, 8'h13);
      step(2);
      chk({31'h0, chan3RxData}, 32'h1);
      wr(OFF_CHAN3_PORT_CONTROL, 8'h00);
      chan3Level <= 1'b1;
   endtask

   // Infrared pulse width for every allowed code, then plain mode
   task automatic t_ir();
      logic [7:0] width [5] = '{8'h03, 8'h02, 8'h04, 8'h08, 8'h10};
      wr(OFF_EXTENDED_MODE, 8'h00);
      tickMode <= 2'h2;
      chan1TxData <= 1'b0;
      chan1Level <= 1'b1;
      for (int c = 0; c < 5; c++) begin
         wr(OFF_INFRARED_CONTROL, 8'h80 | (8'(c) << 4));
         step(2);
         chan1BitStart <= 1'b1;
         step(1);
         chan1BitStart <= 1'b0;
         step(24);
         chk({24'h0, pulseLen}, {24'h0, width[c]});
      end
      chk({31'h0, chan1RxData}, 32'h0);
      wr(OFF_INFRARED_CONTROL, 8'h00);
      step(3);
      chk({31'h0, chan1TxPin}, 32'h0);
      chan1TxData <= 1'b1;
      step(3);
      chk({31'h0, chan1TxPin}, 32'h1);
      tickMode <= 2'h0;
   endtask

   // Oversampling ratio, mode gating and bit-centre sampling
   task automatic t_rx();
      int n;
      for (int s = 0; s < 2; s++) begin
         // Clear any frame left open by earlier route switching
         chan1FrameDone <= 1'b1;
         step(1);
         chan1FrameDone <= 1'b0;
         wr(OFF_EXTENDED_MODE, s[0] ? 8'h08 : 8'h00);
         wr(OFF_CHAN1_MODE, 8'h00);
         step(2);
         chk({31'h0, chan1Oversample8}, {31'h0, s[0]});
         chan1Level <= 1'b0;
         step(12);
         tickMode <= 2'h1;
         n = 0;
         for (int k = 0; k < 200; k++) begin
            @(posedge sys_clk);
            if (oversampleTick === 1'b1) n++;
            if (chan1SampleStrobe === 1'b1) break;
         end
         chk(32'(n), s[0] ? 32'h4 : 32'h8);
         tickMode <= 2'h0;
         chan1Level <= 1'b1;
         step(4);
      end
      wr(OFF_CHAN1_MODE, 8'h01);
      step(2);
      chk({31'h0, chan1Oversample8}, 32'h0);
      wr(OFF_EXTENDED_MODE, 8'h00);
      wr(OFF_CHAN1_MODE, 8'h00);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      {psel, penable, pwrite, chan3TxData, portOutData, portDriveEnable} = 6'h01;
      {chan1BitStart, chan1FrameDone, oversampleTick} = 3'h0;
      {chan3Level, chan1Level, chan1TxData} = 3'h7;
      paddr = 8'h00;
      pwdata = 32'h0;
      tickMode = 2'h0;
      cyc = 0;
      errorCnt = 0;
      checkCount = 0;
      step(2);
      reset <= 1'b0;
      t_regs();
      t_chan3();
      t_ir();
      t_rx();
      summarize();
   end
endmodule
